// *** pkg/fcf_map.svh ***
`ifndef FCF_MAP_SVH
`define FCF_MAP_SVH

// ****************************************
// fault codes
// ****************************************
`define FCF_TYPE_FLOAT 8'h04
`define FCF_TYPE_CONSTRAINT 8'h05
`define FCF_SUB_RANGE 8'h01
`define FCF_SUB_NONE 8'h00

// ****************************************
// floating subtype bit positions
// ****************************************
`define FCF_FB_OVF 0
`define FCF_FB_UNF 1
`define FCF_FB_INV 2
`define FCF_FB_ZDIV 3
`define FCF_FB_INX 4
`define FCF_FB_RESENC 5

// ****************************************
// register offsets
// ****************************************
`define FCF_OFS_CTRL 8'h00
`define FCF_OFS_STATUS 8'h04
`define FCF_OFS_MASK 8'h08
`define FCF_OFS_LAST 8'h0C

// ****************************************
// control and status fields
// ****************************************
`define FCF_CTRL_CON_EN 0
`define FCF_CTRL_FP_EN 1
`define FCF_ST_CON 0
`define FCF_ST_FPRE 1
`define FCF_ST_FPOST 2
`define FCF_ST_LOST 3

// ****************************************
// reset values
// ****************************************
`define FCF_CTRL_RST 2'h3
`define FCF_MASK_RST 4'h0

`endif

// *** pkg/fcf_pkg.sv ***
`default_nettype none
package fcf_pkg;

  // arithmetic controls as seen by the classifier
  typedef struct packed {
    logic [2:0] cc;
    logic norm_mode;
    logic mask_ovf;
    logic mask_unf;
    logic mask_inv;
    logic mask_zdiv;
    logic mask_inx;
  } fcf_arith_ctl_s;

  // fault-if instruction completing
  typedef struct packed {
    logic valid;
    logic [2:0] cond;
    logic [31:0] ip;
  } fcf_faultif_s;

  // floating operation at issue, before it executes
  typedef struct packed {
    logic valid;
    logic inv_operand;
    logic is_div;
    logic divisor_zero;
    logic denorm_src;
    logic [31:0] ip;
    logic [31:0] next_ip;
  } fcf_fp_issue_s;

  // floating operation at commit, after the destination is written
  typedef struct packed {
    logic valid;
    logic ovf;
    logic unf;
    logic inx;
    logic round_up;
    logic bias_adj;
    logic [79:0] adj_result;
    logic [31:0] ip;
    logic [31:0] next_ip;
  } fcf_fp_commit_s;

  // fault record handed to the dispatch logic
  typedef struct packed {
    logic [7:0] ftype;
    logic [7:0] subtype;
    logic [1:0] flags;
    logic [79:0] fdata;
    logic [31:0] fault_ip;
    logic [31:0] saved_ip;
    logic saved_ip_used;
  } fcf_record_s;

  typedef enum logic [1:0] {
    FCF_SRC_NONE = 2'b00,
    FCF_SRC_CON = 2'b01,
    FCF_SRC_FPRE = 2'b10,
    FCF_SRC_FPOST = 2'b11
  } fcf_src_e;

endpackage : fcf_pkg
`default_nettype wire

// *** hw/fcf_fp_classify.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "fcf_map.svh"
module fcf_fp_classify (
  input wire fcf_pkg::fcf_arith_ctl_s ctl,
  input wire fcf_pkg::fcf_fp_issue_s iss,
  input wire fcf_pkg::fcf_fp_commit_s cmt,
  output logic pre_fire,
  output logic [7:0] pre_sub,
  output logic post_fire,
  output logic [7:0] post_sub,
  output logic [1:0] post_flags,
  output logic [79:0] post_fdata
);
  import fcf_pkg::*;

  // ****************************************
  // checks before execution
  // ****************************************
  wire resenc_hit = iss.valid & iss.denorm_src & ~ctl.norm_mode;
  wire inv_hit = iss.valid & iss.inv_operand & ~ctl.mask_inv;
  wire zdiv_hit = iss.valid & iss.is_div & iss.divisor_zero & ~ctl.mask_zdiv;

  // one bit only: reserved encoding, then invalid, then zero divide
  wire resenc_sel = resenc_hit;
  wire inv_sel = inv_hit & ~resenc_hit;
  wire zdiv_sel = zdiv_hit & ~resenc_hit & ~inv_hit;

  assign pre_fire = resenc_hit | inv_hit | zdiv_hit;
  assign pre_sub = {2'b00, 1'b0, 1'b0, 4'h0}
    | (8'h01 << `FCF_FB_RESENC) * {7'h00, resenc_sel}
    | (8'h01 << `FCF_FB_INV) * {7'h00, inv_sel}
    | (8'h01 << `FCF_FB_ZDIV) * {7'h00, zdiv_sel};

  // ****************************************
  // checks after the result is written
  // ****************************************
  wire ovf_hit = cmt.valid & cmt.ovf & ~ctl.mask_ovf;
  wire unf_hit = cmt.valid & cmt.unf & ~cmt.ovf & ~ctl.mask_unf;
  wire inx_hit = cmt.valid & cmt.inx & ~ctl.mask_inx;
  wire range_hit = ovf_hit | unf_hit;

  assign post_fire = range_hit | inx_hit;
  assign post_sub = {2'b00, 1'b0, inx_hit, 1'b0, 1'b0, unf_hit, ovf_hit};
  assign post_flags = {range_hit & cmt.bias_adj, range_hit & inx_hit & cmt.round_up};
  assign post_fdata = range_hit ? cmt.adj_result : 80'h0;

endmodule : fcf_fp_classify
`default_nettype wire

// *** hw/fcf_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "fcf_map.svh"
module fcf_top #(
  parameter int ADR_W = 8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire fcf_pkg::fcf_arith_ctl_s ctl,
  input wire fcf_pkg::fcf_faultif_s fif,
  input wire fcf_pkg::fcf_fp_issue_s iss,
  input wire fcf_pkg::fcf_fp_commit_s cmt,
  output logic fp_squash,
  output logic fault_valid,
  output var fcf_pkg::fcf_record_s fault_rec,
  input wire logic [ADR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq
);
  import fcf_pkg::*;

  // ****************************************
  // elaboration checks
  // ****************************************
  generate
    if (ADR_W < 4) begin : g_bad_adr
      $error("fcf_top: ADR_W must be at least 4");
    end
  endgenerate

  // ****************************************
  // helpers
  // ****************************************
  // fault-if holds a mask of conditions; an all-zero mask asks for the unordered code
  function automatic logic cc_match(input logic [2:0] cc, input logic [2:0] cond);
    cc_match = (cond == 3'b000) ? (cc == 3'b000) : ((cc & cond) != 3'b000);
  endfunction : cc_match

  function automatic logic [ADR_W-1:0] ofs(input logic [7:0] o);
    ofs = ADR_W'(o);
  endfunction : ofs

  // ****************************************
  // register state
  // ****************************************
  logic [1:0] ctrl_r;
  logic [3:0] status_r;
  logic [3:0] mask_r;
  logic [15:0] last_r;
  logic [31:0] rdata_r;
  logic valid_r;
  fcf_record_s rec_r;

  wire con_en = ctrl_r[`FCF_CTRL_CON_EN];
  wire fp_en = ctrl_r[`FCF_CTRL_FP_EN];

  // ****************************************
  // floating classifier
  // ****************************************
  logic pre_fire;
  logic [7:0] pre_sub;
  logic post_fire;
  logic [7:0] post_sub;
  logic [1:0] post_flags;
  logic [79:0] post_fdata;

  fcf_fp_classify u_cls (
    .ctl(ctl),
    .iss(iss),
    .cmt(cmt),
    .pre_fire(pre_fire),
    .pre_sub(pre_sub),
    .post_fire(post_fire),
    .post_sub(post_sub),
    .post_flags(post_flags),
    .post_fdata(post_fdata)
  );

  // ****************************************
  // event detection
  // ****************************************
  // constraint check runs only on a completed fault-if, so nothing is undone
  wire con_ev = con_en & fif.valid & cc_match(ctl.cc, fif.cond);
  wire fpre_ev = fp_en & pre_fire;
  wire fpost_ev = fp_en & post_fire;

  // the execution unit must not execute an operand-faulting op
  assign fp_squash = fpre_ev;

  // one report per cycle; losers are counted as lost, not queued
  wire [1:0] src_sel = con_ev ? FCF_SRC_CON :
                       fpre_ev ? FCF_SRC_FPRE :
                       fpost_ev ? FCF_SRC_FPOST : FCF_SRC_NONE;
  wire [1:0] ev_cnt = 2'(con_ev) + 2'(fpre_ev) + 2'(fpost_ev);
  wire lost_ev = ev_cnt > 2'd1;

  // ****************************************
  // record assembly
  // ****************************************
  fcf_record_s rec_nxt;

  always_comb begin
    rec_nxt = '0;
    case (fcf_src_e'(src_sel))
      FCF_SRC_CON: begin
        rec_nxt.ftype = `FCF_TYPE_CONSTRAINT;
        rec_nxt.subtype = `FCF_SUB_RANGE;
        rec_nxt.flags = 2'h0;
        rec_nxt.fdata = 80'h0;
        rec_nxt.fault_ip = fif.ip;
        rec_nxt.saved_ip = 32'h0;
        rec_nxt.saved_ip_used = 1'b0;
      end
      FCF_SRC_FPRE: begin
        rec_nxt.ftype = `FCF_TYPE_FLOAT;
        rec_nxt.subtype = pre_sub;
        rec_nxt.flags = 2'h0;
        rec_nxt.fdata = 80'h0;
        rec_nxt.fault_ip = iss.ip;
        rec_nxt.saved_ip = iss.next_ip;
        rec_nxt.saved_ip_used = 1'b1;
      end
      FCF_SRC_FPOST: begin
        rec_nxt.ftype = `FCF_TYPE_FLOAT;
        rec_nxt.subtype = post_sub;
        rec_nxt.flags = post_flags;
        rec_nxt.fdata = post_fdata;
        rec_nxt.fault_ip = cmt.ip;
        rec_nxt.saved_ip = cmt.next_ip;
        rec_nxt.saved_ip_used = 1'b1;
      end
      default: begin
        rec_nxt = rec_r;
      end
    endcase
  end

  wire report_ev = src_sel != FCF_SRC_NONE;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rec_r <= '0;
      valid_r <= 1'b0;
    end else begin
      rec_r <= rec_nxt;
      valid_r <= report_ev;
    end
  end

  assign fault_valid = valid_r;
  assign fault_rec = rec_r;

  // ****************************************
  // register decode
  // ****************************************
  wire hit_ctrl = reg_addr == ofs(`FCF_OFS_CTRL);
  wire hit_status = reg_addr == ofs(`FCF_OFS_STATUS);
  wire hit_mask = reg_addr == ofs(`FCF_OFS_MASK);
  wire hit_last = reg_addr == ofs(`FCF_OFS_LAST);

  wire wr_ctrl = reg_wr & hit_ctrl;
  wire wr_status = reg_wr & hit_status;
  wire wr_mask = reg_wr & hit_mask;

  // ****************************************
  // sticky status, set wins over clear
  // ****************************************
  wire [3:0] st_set = {lost_ev, fpost_ev, fpre_ev, con_ev};
  wire [3:0] st_clr = wr_status ? reg_wdata[3:0] : 4'h0;
  wire [3:0] status_nxt = (status_r & ~st_clr) | st_set;

  wire [1:0] ctrl_nxt = wr_ctrl ? reg_wdata[1:0] : ctrl_r;
  wire [3:0] mask_nxt = wr_mask ? reg_wdata[3:0] : mask_r;
  wire [15:0] last_nxt = report_ev ? {rec_nxt.ftype, rec_nxt.subtype} : last_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_r <= `FCF_CTRL_RST;
      mask_r <= `FCF_MASK_RST;
      status_r <= 4'h0;
      last_r <= 16'h0000;
    end else begin
      ctrl_r <= ctrl_nxt;
      mask_r <= mask_nxt;
      status_r <= status_nxt;
      last_r <= last_nxt;
    end
  end

  // ****************************************
  // read path, unmapped reads return zero
  // ****************************************
  wire [31:0] rd_mux = hit_ctrl ? {30'h0, ctrl_r} :
                       hit_status ? {28'h0, status_r} :
                       hit_mask ? {28'h0, mask_r} :
                       hit_last ? {16'h0, last_r} : 32'h0;
  wire [31:0] rdata_nxt = reg_rd ? rd_mux : 32'h0;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_r <= 32'h0;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;

  // ****************************************
  // interrupt
  // ****************************************
  // a mask bit of one enables that status bit onto the line
  assign irq = |(status_r & mask_r);

endmodule : fcf_top
`default_nettype wire

// *** tb/fcf_top_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module fcf_checker (
  input wire logic clk,
  input wire logic nrst,
  input wire fcf_pkg::fcf_arith_ctl_s ctl,
  input wire fcf_pkg::fcf_faultif_s fif,
  input wire fcf_pkg::fcf_fp_issue_s iss,
  input wire logic fp_squash,
  input wire logic fault_valid,
  input wire fcf_pkg::fcf_record_s fault_rec,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata
);
  import fcf_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_con_rec;
    fault_valid && fault_rec.ftype == 8'h05 |-> fault_rec.subtype == 8'h01 && fault_rec.flags == 2'b00
      && fault_rec.fdata == 80'h0 && !fault_rec.saved_ip_used;
  endproperty
  a_con_rec: assert property (p_con_rec) else $error("constraint record malformed");
  property p_type;
    fault_valid |-> fault_rec.ftype inside {8'h04, 8'h05};
  endproperty
  a_type: assert property (p_type) else $error("unknown fault type");
  property p_fp_resv;
    fault_valid && fault_rec.ftype == 8'h04 |-> fault_rec.subtype[7:6] == 2'b00 && fault_rec.saved_ip_used;
  endproperty
  a_fp_resv: assert property (p_fp_resv) else $error("float subtype reserved bits set");
  property p_fp_alone;
    fault_valid && fault_rec.ftype == 8'h04 && (fault_rec.subtype & 8'h2C) != 8'h00 |-> $onehot(fault_rec.subtype);
  endproperty
  a_fp_alone: assert property (p_fp_alone) else $error("pre-execution fault not alone");
  property p_squash_cause;
    fp_squash |-> iss.valid && (iss.denorm_src && !ctl.norm_mode || iss.inv_operand && !ctl.mask_inv
      || iss.is_div && iss.divisor_zero && !ctl.mask_zdiv);
  endproperty
  a_squash_cause: assert property (p_squash_cause) else $error("squash without cause");
  property p_resenc;
    iss.valid && iss.denorm_src && !ctl.norm_mode && !fif.valid |-> fp_squash ##1
      (fault_valid && fault_rec.subtype == 8'h20);
  endproperty
  a_resenc: assert property (p_resenc) else $error("reserved encoding missed");
  property p_pre_ip;
    fp_squash && !fif.valid |=> fault_valid && fault_rec.fault_ip == $past(iss.ip)
      && fault_rec.saved_ip == $past(iss.next_ip);
  endproperty
  a_pre_ip: assert property (p_pre_ip) else $error("pre fault addresses wrong");
  property p_inx_alone;
    fault_valid && fault_rec.ftype == 8'h04 && fault_rec.subtype == 8'h10 |->
      fault_rec.flags == 2'b00 && fault_rec.fdata == 80'h0;
  endproperty
  a_inx_alone: assert property (p_inx_alone) else $error("inexact alone carries data");
  property p_rdata;
    !reg_rd |=> reg_rdata == 32'h0;
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data outside read slot");
endmodule : fcf_checker
bind fcf_top fcf_checker u_chk (.clk(clk), .nrst(nrst), .ctl(ctl), .fif(fif), .iss(iss),
  .fp_squash(fp_squash), .fault_valid(fault_valid), .fault_rec(fault_rec), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata));
`default_nettype wire

// *** tb/fcf_exec_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module fcf_exec_model (
  input wire logic clk,
  output var fcf_pkg::fcf_arith_ctl_s ctl,
  output var fcf_pkg::fcf_faultif_s fif,
  output var fcf_pkg::fcf_fp_issue_s iss,
  output var fcf_pkg::fcf_fp_commit_s cmt
);
  import fcf_pkg::*;
  initial begin
    ctl = '0;
    fif = '0;
    iss = '0;
    cmt = '0;
  end
  task automatic fire(input fcf_arith_ctl_s c, input fcf_faultif_s f, input fcf_fp_issue_s i,
                      input fcf_fp_commit_s m);
    @(posedge clk);
    ctl <= c;
    fif <= f;
    iss <= i;
    cmt <= m;
    #1;
  endtask : fire
  // ****************************************
  // payload is scrambled once valid drops, so a stale ip cannot pass for a live one
  // ****************************************
  task automatic idle();
    fcf_faultif_s f;
    fcf_fp_issue_s i;
    fcf_fp_commit_s m;
    @(posedge clk);
    f = ~fif;
    i = ~iss;
    m = ~cmt;
    f.valid = 1'b0;
    i.valid = 1'b0;
    m.valid = 1'b0;
    fif <= f;
    iss <= i;
    cmt <= m;
    #1;
  endtask : idle
endmodule : fcf_exec_model
`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import fcf_pkg::*;
  localparam logic [79:0] ADJ = 80'hA5C3_0F1E_2D3C_4B5A_6978;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic irq;
  logic fp_squash;
  logic fault_valid;
  fcf_arith_ctl_s ctl;
  fcf_faultif_s fif;
  fcf_fp_issue_s iss;
  fcf_fp_commit_s cmt;
  fcf_record_s fault_rec;
  int failures = 0;
  int num_checks = 0;
  logic [4:0] pre_in [4] = '{5'h11, 5'h18, 5'h16, 5'h1F};
  logic [7:0] pre_sub [4] = '{8'h20, 8'h04, 8'h08, 8'h20};
  always #4 clk = ~clk;
  fcf_exec_model exe (.clk(clk), .ctl(ctl), .fif(fif), .iss(iss), .cmt(cmt));
  fcf_top #(.ADR_W(8)) dut (.clk(clk), .nrst(nrst), .ctl(ctl), .fif(fif), .iss(iss), .cmt(cmt),
    .fp_squash(fp_squash), .fault_valid(fault_valid), .fault_rec(fault_rec), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
  task automatic chk(input string n, input logic [191:0] e, input logic [191:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", e, reg_rdata);
  endtask : rd
  // ****************************************
  // one event in, squash seen in its cycle, report one cycle later
  // ****************************************
  task automatic ev(input fcf_arith_ctl_s c, input fcf_faultif_s f, input fcf_fp_issue_s i,
                    input fcf_fp_commit_s m, input logic sq, input logic fv, input fcf_record_s e);
    fcf_record_s g;
    exe.fire(c, f, i, m);
    if (sq !== 1'bx) chk("fp_squash", sq, fp_squash);
    exe.idle();
    chk("fault_valid", fv, fault_valid);
    g = fault_rec;
    if (!e.saved_ip_used) g.saved_ip = e.saved_ip;
    if (fv) chk("fault_rec", e, g);
  endtask : ev
  task automatic wrap_up();
    if (failures == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up
  initial begin
    #100000;
    failures++;
    wrap_up();
  end
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    rd(8'h00, 32'h3);
    rd(8'h08, 32'h0);
    rd(8'h10, 32'h0);
    chk("irq", 1'b0, irq);
    ev({3'd2, 6'h0}, {1'b1, 3'd2, 32'h100}, '0, '0, 1'b0, 1'b1,
      {16'h0501, 82'h0, 32'h100, 33'h0});
    ev({3'd1, 6'h0}, {1'b1, 3'd2, 32'h104}, '0, '0, 1'b0, 1'b0, '0);
    ev({3'd0, 6'h0}, {1'b1, 3'd0, 32'h108}, '0, '0, 1'b0, 1'b1,
      {16'h0501, 82'h0, 32'h108, 33'h0});
    for (int k = 0; k < 4; k++) begin
      ev('0, '0, {pre_in[k], 64'h200_0000_0204}, '0, 1'b1, 1'b1,
        {8'h04, pre_sub[k], 82'h0, 64'h200_0000_0204, 1'b1});
    end
    ev({3'd0, 6'h04}, '0, {5'h18, 64'h0}, '0, 1'b0, 1'b0, '0);
    ev({3'd0, 6'h20}, '0, {5'h11, 64'h0}, '0, 1'b0, 1'b0, '0);
    ev('0, '0, '0, {6'h37, ADJ, 64'h300_0000_0304}, 1'b0, 1'b1,
      {16'h0411, 2'b11, ADJ, 64'h300_0000_0304, 1'b1});
    ev('0, '0, '0, {6'h29, ADJ, 64'h300_0000_0304}, 1'b0, 1'b1,
      {16'h0402, 2'b10, ADJ, 64'h300_0000_0304, 1'b1});
    ev('0, '0, '0, {6'h26, ADJ, 64'h300_0000_0304}, 1'b0, 1'b1,
      {16'h0410, 82'h0, 64'h300_0000_0304, 1'b1});
    ev({3'd0, 6'h10}, '0, '0, {6'h37, ADJ, 64'h300_0000_0304}, 1'b0, 1'b1,
      {16'h0410, 82'h0, 64'h300_0000_0304, 1'b1});
    rd(8'h04, 32'h7);
    wr(8'h04, 32'hF);
    ev({3'd4, 6'h0}, {1'b1, 3'd4, 32'h400}, {5'h11, 64'h0}, '0, 1'b1, 1'b1,
      {16'h0501, 82'h0, 32'h400, 33'h0});
    rd(8'h04, 32'hB);
    wr(8'h08, 32'h1);
    chk("irq", 1'b1, irq);
    wr(8'h04, 32'h1);
    chk("irq", 1'b0, irq);
    rd(8'h0C, 32'h0501);
    wr(8'h00, 32'h2);
    ev({3'd2, 6'h0}, {1'b1, 3'd2, 32'h500}, '0, '0, 1'b0, 1'b0, '0);
    wr(8'h00, 32'h1);
    ev('0, '0, {5'h18, 64'h0}, '0, 1'b0, 1'b0, '0);
    wr(8'h00, 32'h3);
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
